// ==== core/status_led_enable_control.sv ====
/*
 * status indicator lighting control: an enable mask with set-to-disable
 * and set-to-enable commands, a data link driven indicator with blink,
 * and an apb register slave.
 * assumes a single clock clk_sys at 50 MHz, link state from logic on the
 * same clock, and an apb master that holds each request until pready.
 */
// Added by the designer: the register addresses and the APB register port.
//
// How it works
// (RULE_01) disable bits: 0 run, 1 user two, 3 error
// (RULE_02) disable bits: 5 user one, 6 data link
// (RULE_03) bits 9, 10 line errors; rest unused
// (RULE_04) disable write: ones clear, zeros hold
// (RULE_05) disable write with unused bits errors out
// (RULE_06) enable word uses the same bit positions
// (RULE_07) enable write: ones set, zeros hold
// (RULE_08) enable write with unused bits errors out
// (RULE_09) refresh drives run, error, link from state
// (RULE_10) link running: data link indicator steady on
// (RULE_11) link stopped: data link blinks, 500 ms period
// (RULE_12) no link: data link indicator off
// (RULE_13) disabled indicator stays off; rejected write inert
// (RULE_14) blink counted in clocks, equal halves
//
`timescale 1ns/1ps

`include "status_led_defs.svh"

module status_led_enable_control
   import status_led_pkg::*;
#(
   parameter int ADDR_W      = 12,
   parameter int HALF_CYCLES = `BLINK_HALF_CYCLES
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [1:0]        data_link_state,
   output indicators_t            indicators
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   localparam int CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("address width must lie between 5 and 32");
   end
   if (HALF_CYCLES < 1) begin : g_bad_half
      $error("blink half period must be at least one cycle");
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   bus_phase_t               phase_reg;
   logic [`MASK_W-1:0]       enable_reg;
   logic [`MASK_W-1:0]       manual_reg;
   link_state_t              applied_reg;
   logic                     reject_reg;
   logic [CNT_W-1:0]         blink_cnt_reg;
   logic                     blink_reg;
   logic [31:0]              prdata_reg;
   logic                     pready_reg;
   logic                     pslverr_reg;
   indicators_t              indicators_reg;
   indicators_t              indicators_next;

   // latched decode of the request under answer
   logic                     wr_ok_reg;
   logic [ADDR_W-1:0]        addr_hold_reg;
   logic [`MASK_W-1:0]       data_hold_reg;

   // ----------------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------------
   logic                     access_start;
   logic                     access_done;
   logic [11:0]              ofs;
   logic                     hit;
   logic                     is_mask_cmd;
   logic                     has_unused;
   logic                     bad_req;
   logic [31:0]              rd_word;
   link_state_t              live_state;

   assign access_start = psel && penable && (phase_reg == BUS_IDLE);
   assign access_done  = psel && penable && (phase_reg == BUS_ANSWER);
   assign ofs          = 12'(paddr);

   always_comb begin
      hit = 1'b0;
      unique case (ofs)
         `OFS_ENABLE_STATE,
         `OFS_DISABLE_CMD,
         `OFS_ENABLE_CMD,
         `OFS_REFRESH_CMD,
         `OFS_MANUAL_REQ,
         `OFS_STATUS: hit = 1'b1;
         default:     hit = 1'b0;
      endcase
      if (ADDR_W > 12 && (paddr >> 12) != '0) begin
         hit = 1'b0;
      end
   end

   assign is_mask_cmd = pwrite &&
      (ofs == `OFS_DISABLE_CMD || ofs == `OFS_ENABLE_CMD);

   // any one outside the used positions refuses the command
   assign has_unused = (pwdata & ~(`MASK_USED)) != 32'h0000_0000; // [RULE_03]

   assign bad_req = !hit || (is_mask_cmd && has_unused); // [RULE_05] [RULE_08]

   // illegal code 3 on the link input is read as no link
   always_comb begin
      unique case (data_link_state)
         2'h1:    live_state = LINK_STOPPED;
         2'h2:    live_state = LINK_RUNNING;
         default: live_state = LINK_NONE;
      endcase
   end

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (ofs)
         `OFS_ENABLE_STATE: rd_word = 32'(enable_reg);
         `OFS_MANUAL_REQ:   rd_word = 32'(manual_reg);
         `OFS_STATUS: begin
            rd_word[`STAT_APPLIED_LSB +: 2] = applied_reg;
            rd_word[`STAT_REJECT_BIT]       = reject_reg;
            rd_word[`STAT_LIVE_LSB +: 2]    = live_state;
         end
         default:           rd_word = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------
   // apb answer: one wait cycle, then pready for one cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase_reg   <= BUS_IDLE;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (ce) begin
         if (access_start) begin
            phase_reg   <= BUS_ANSWER;
            pready_reg  <= 1'b1;
            pslverr_reg <= bad_req; // [RULE_05] [RULE_08]
            prdata_reg  <= (pwrite || !hit) ? 32'h0000_0000 : rd_word;
         end else begin
            phase_reg   <= BUS_IDLE;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
         end
      end
   end

   // decode is frozen at the first access edge so the commit at the
   // pready edge matches the answer already given
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ok_reg     <= 1'b0;
         addr_hold_reg <= '0;
         data_hold_reg <= '0;
      end else if (ce) begin
         if (access_start) begin
            wr_ok_reg     <= pwrite && !bad_req; // [RULE_13]
            addr_hold_reg <= paddr;
            data_hold_reg <= pwdata[`MASK_W-1:0];
         end else begin
            wr_ok_reg     <= 1'b0;
         end
      end
   end

   logic commit;
   logic [11:0] hold_ofs;
   assign commit   = access_done && wr_ok_reg;
   assign hold_ofs = 12'(addr_hold_reg);

   // ----------------------------------------------------------------------
   // lighting enable mask
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         enable_reg <= `MASK_RESET;
      end else if (ce && commit) begin
         if (hold_ofs == `OFS_DISABLE_CMD) begin
            // ones clear, zeros keep; same positions both ways
            enable_reg <= enable_reg & ~data_hold_reg; // [RULE_04] [RULE_01]
         end else if (hold_ofs == `OFS_ENABLE_CMD) begin
            enable_reg <= enable_reg | data_hold_reg; // [RULE_07] [RULE_06]
         end
      end
   end

   // ----------------------------------------------------------------------
   // manual requests for user and line error indicators
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         manual_reg <= '0;
      end else if (ce && commit && hold_ofs == `OFS_MANUAL_REQ) begin
         manual_reg <= data_hold_reg & `MASK_W'(`MASK_MANUAL);
      end
   end

   // ----------------------------------------------------------------------
   // rejected command flag
   // ----------------------------------------------------------------------
   // set wins: a refused command in the same edge as a good one is kept
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reject_reg <= 1'b0;
      end else if (ce) begin
         if (access_start && is_mask_cmd && has_unused) begin
            reject_reg <= 1'b1; // [RULE_05] [RULE_08]
         end else if (commit &&
                      (hold_ofs == `OFS_DISABLE_CMD ||
                       hold_ofs == `OFS_ENABLE_CMD)) begin
            reject_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // refresh: the link state is taken only on command
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         applied_reg <= LINK_NONE;
      end else if (ce && commit && hold_ofs == `OFS_REFRESH_CMD) begin
         applied_reg <= live_state; // [RULE_09]
      end
   end

   // ----------------------------------------------------------------------
   // blink timebase
   // ----------------------------------------------------------------------
   // free running, so the phase seen after a refresh is not aligned
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (ce) begin
         if (blink_cnt_reg == CNT_W'(HALF_CYCLES - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg     <= !blink_reg; // [RULE_14] [RULE_11]
         end else begin
            blink_cnt_reg <= blink_cnt_reg + CNT_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------------
   // indicator drive
   // ----------------------------------------------------------------------
   always_comb begin
      indicators_next = '0;
      unique case (applied_reg)
         LINK_RUNNING: indicators_next.data_link = 1'b1; // [RULE_10]
         LINK_STOPPED: indicators_next.data_link = blink_reg; // [RULE_11]
         default:      indicators_next.data_link = 1'b0; // [RULE_12]
      endcase
      indicators_next.run   = applied_reg != LINK_NONE; // [RULE_09]
      indicators_next.error = applied_reg == LINK_NONE; // [RULE_09]
      indicators_next.user_one     = manual_reg[`BIT_USER_ONE];
      indicators_next.user_two     = manual_reg[`BIT_USER_TWO];
      indicators_next.line_err_one = manual_reg[`BIT_LINE_ERR_ONE];
      indicators_next.line_err_two = manual_reg[`BIT_LINE_ERR_TWO];

      // a disabled indicator is held dark whatever is asked
      indicators_next.run       &= enable_reg[`BIT_RUN]; // [RULE_13] [RULE_01]
      indicators_next.user_two  &= enable_reg[`BIT_USER_TWO]; // [RULE_01]
      indicators_next.error     &= enable_reg[`BIT_ERROR]; // [RULE_01]
      indicators_next.user_one  &= enable_reg[`BIT_USER_ONE]; // [RULE_02]
      indicators_next.data_link &= enable_reg[`BIT_DATA_LINK]; // [RULE_02]
      indicators_next.line_err_one &=
         enable_reg[`BIT_LINE_ERR_ONE]; // [RULE_03]
      indicators_next.line_err_two &=
         enable_reg[`BIT_LINE_ERR_TWO]; // [RULE_03]
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         indicators_reg <= '0;
      end else if (ce) begin
         indicators_reg <= indicators_next; // [RULE_13]
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign prdata     = prdata_reg;
   assign pready     = pready_reg;
   assign pslverr    = pslverr_reg;
   assign indicators = indicators_reg;

endmodule

// ==== common/status_led_defs.svh ====
/*
 * constants of the status indicator lighting block: register offsets,
 * mask field positions, reset values and blink timing.
 * assumes inclusion by the core module, the checker and the bench.
 */
`ifndef STATUS_LED_DEFS_SVH
`define STATUS_LED_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_ENABLE_STATE   12'h000
`define OFS_DISABLE_CMD    12'h004
`define OFS_ENABLE_CMD     12'h008
`define OFS_REFRESH_CMD    12'h00C
`define OFS_MANUAL_REQ     12'h010
`define OFS_STATUS         12'h014

// ----------------------------------------------------------------------
// lighting mask bit positions
// ----------------------------------------------------------------------
`define BIT_RUN            0
`define BIT_USER_TWO       1
`define BIT_ERROR          3
`define BIT_USER_ONE       5
`define BIT_DATA_LINK      6
`define BIT_LINE_ERR_ONE   9
`define BIT_LINE_ERR_TWO   10

`define MASK_W             16
`define MASK_USED          32'h0000_066B
`define MASK_MANUAL        32'h0000_0622
`define MASK_RESET         16'h066B

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STAT_APPLIED_LSB   0
`define STAT_REJECT_BIT    2
`define STAT_LIVE_LSB      4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_HZ             50000000
`define BLINK_PERIOD_MS    500
`define BLINK_HALF_CYCLES  ((`CLK_HZ / 1000) * `BLINK_PERIOD_MS / 2)

`endif

// ==== common/status_led_pkg.sv ====
/*
 * types of the status indicator lighting block.
 * assumes status_led_defs.svh sits beside it on the include path.
 */
package status_led_pkg;

   // ----------------------------------------------------------------------
   // data link state, as seen by the refresh command
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      LINK_NONE,
      LINK_STOPPED,
      LINK_RUNNING
   } link_state_t;

   // ----------------------------------------------------------------------
   // bus answer sequencing
   // ----------------------------------------------------------------------
   typedef enum logic {
      BUS_IDLE,
      BUS_ANSWER
   } bus_phase_t;

   // ----------------------------------------------------------------------
   // indicator drive levels, one bit each, high means lit
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic run;
      logic error;
      logic data_link;
      logic user_one;
      logic user_two;
      logic line_err_one;
      logic line_err_two;
   } indicators_t;

endpackage

// ==== verification/status_led_chk.sv ====
/*
 * checker of the status indicator block: bus answers and indicator
 * relations. assumes binding onto status_led_enable_control.
 */
`timescale 1ns/1ps
`include "status_led_defs.svh"
module status_led_chk
   import status_led_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              ce,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [1:0]        data_link_state,
   input wire indicators_t       indicators
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic hit = paddr <= `OFS_STATUS && paddr[1:0] == 2'h0;
   wire logic cmd = paddr == `OFS_DISABLE_CMD || paddr == `OFS_ENABLE_CMD;
   wire logic bad = pwrite && cmd && |(pwdata & ~`MASK_USED);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_take;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_answer; s_take |=> s_answer; endproperty
   property p_idle; !(psel && penable) |=> !pready; endproperty
   property p_miss; s_take ##0 !hit |=> pslverr && prdata == 0; endproperty
   property p_bad; s_take ##0 bad |=> pready && pslverr; endproperty
   property p_good; s_take ##0 hit && !bad |=> !pslverr; endproperty
   property p_excl; !(indicators.run && indicators.error); endproperty
   property p_link; indicators.data_link |-> !indicators.error; endproperty
   property p_state;
      pready && !pwrite && paddr == `OFS_ENABLE_STATE
         |-> (prdata & ~`MASK_USED) == 0;
   endproperty
   a_answer: assert property (p_answer) else $error("late answer");
   a_idle: assert property (p_idle) else $error("stray pready");
   a_miss: assert property (p_miss) else $error("unmapped ok");
   a_bad: assert property (p_bad) else $error("unused bits ok");
   a_good: assert property (p_good) else $error("good refused");
   a_excl: assert property (p_excl) else $error("run with error");
   a_link: assert property (p_link) else $error("link with error");
   a_state: assert property (p_state) else $error("unused mask bit");
endmodule

bind status_led_enable_control status_led_chk #(.ADDR_W(ADDR_W)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .data_link_state(data_link_state),
   .indicators(indicators));

// ==== verification/tb_status_led_enable_control.sv ====
/*
 * self-checking bench of the status indicator block, random apb traffic.
 * assumes the defs header on the include path and a 4-clock blink half.
 */
`timescale 1ns/1ps
`include "status_led_defs.svh"
module tb_status_led_enable_control
   import status_led_pkg::*;
;
   logic        clk_sys = 0, rst = 1, ce = 1;
   logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = 0, a;
   logic [31:0] pwdata = 0, prdata, rd, d;
   logic [1:0]  dls = 0, m_st = 0;
   logic [15:0] m_mask = `MASK_RESET;
   logic [31:0] m_man = 0;
   logic        m_rej = 0;
   indicators_t indicators;
   int          fail_count = 0, cmp_count = 0, seed = 85, i, ones;
   always #10 clk_sys = ~clk_sys;
   status_led_enable_control #(.ADDR_W(12), .HALF_CYCLES(4)) dut (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .data_link_state(dls), .indicators(indicators));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // caller enters just after a rising edge; returns at the pready edge
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         test_done;
      end
      rd = prdata;
      err = pslverr;
   endtask
   task idle;
      psel <= 0;
      penable <= 0;
      repeat (2) @(posedge clk_sys);
   endtask
   function automatic indicators_t exp_ind();
      indicators_t e;
      e.run = m_mask[0] && m_st != 0;
      e.error = m_mask[3] && m_st == 0;
      e.data_link = m_mask[6] && m_st == 2;
      e.user_one = m_mask[5] && m_man[5];
      e.user_two = m_mask[1] && m_man[1];
      e.line_err_one = m_mask[9] && m_man[9];
      e.line_err_two = m_mask[10] && m_man[10];
      return e;
   endfunction
   // one write or read, model update, then readback of the mask and status registers
   task op(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      logic bad, cmd;
      cmd = ad == `OFS_DISABLE_CMD || ad == `OFS_ENABLE_CMD;
      bad = w && cmd && |(wd & ~`MASK_USED);
      apb(w, ad, wd);
      if (w && ad == `OFS_DISABLE_CMD && !bad) m_mask &= ~wd[15:0];
      if (w && ad == `OFS_ENABLE_CMD && !bad) m_mask |= wd[15:0];
      if (w && cmd) m_rej = bad;
      if (w && ad == `OFS_REFRESH_CMD) m_st = dls == 3 ? 2'h0 : dls;
      if (w && ad == `OFS_MANUAL_REQ) m_man = wd & `MASK_MANUAL;
      chk("pslverr", bad || ad > `OFS_STATUS, err);
      if (ad > `OFS_STATUS) chk("miss_data", 0, rd);
      apb(0, `OFS_ENABLE_STATE, 0);
      chk("mask", {16'h0000, m_mask}, rd);
      apb(0, `OFS_STATUS, 0);
      chk("status", {26'h0, dls == 3 ? 2'h0 : dls, 1'b0, m_rej, m_st},
          rd & 32'h0000_0037);
      idle;
      chk("ind", exp_ind(), indicators & ~(m_st == 1 ? 7'h10 : 7'h00));
   endtask
   task blink(input int e);
      ones = 0;
      for (i = 0; i < 16; i++) begin
         @(posedge clk_sys);
         ones += indicators.data_link;
      end
      chk("blink", e, ones);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 0;
      repeat (2) @(posedge clk_sys);
      chk("ind_reset", 7'h20, indicators);
      op(0, `OFS_ENABLE_STATE, 0);
      $display("test reset done");
      // corner cases first: high unused bit, zero word, full set
      op(1, `OFS_DISABLE_CMD, 32'h0001_0000);
      op(1, `OFS_DISABLE_CMD, 32'h0000_0000);
      op(1, `OFS_MANUAL_REQ, 32'hFFFF_FFFF);
      op(1, `OFS_ENABLE_CMD, 32'h0000_0004);
      op(1, `OFS_DISABLE_CMD, `MASK_USED);
      op(1, `OFS_ENABLE_CMD, `MASK_USED);
      $display("test corners done");
      for (int k = 0; k < 60; k++) begin
         a = ({$random(seed)} % 7) * 4;
         d = $random(seed);
         if (d[31]) d = $random(seed) & `MASK_USED;
         dls <= $random(seed);
         op(a != 12'h018 || d[30], a, d);
      end
      $display("test random done");
      op(1, `OFS_ENABLE_CMD, 32'h0000_0040);
      dls <= 1;
      op(1, `OFS_REFRESH_CMD, 0);
      blink(8);
      op(1, `OFS_DISABLE_CMD, 32'h0000_0040);
      blink(0);
      $display("test blink done");
      test_done;
   end
endmodule
